// File: regbank_pkg.sv
`default_nettype none
package regbank_pkg;
   // ---------------------------------------------
   // register addresses
   // ---------------------------------------------
   localparam logic [7:0] A_ADC_RESULT = 8'h9d;
   localparam logic [7:0] A_ADC_CTRL_A = 8'h9f;
   localparam logic [7:0] A_ADC_CTRL_B = 8'ha0;
   localparam logic [7:0] A_GATE_DELAY = 8'ha2;
   localparam logic [7:0] A_PWM_PRESCALE = 8'ha4;
   localparam logic [7:0] A_DEAD_TIME = 8'ha5;
   localparam logic [7:0] A_CMP_A_LO = 8'ha6;
   localparam logic [7:0] A_CMP_A_HI = 8'ha7;
   localparam logic [7:0] A_CMP_B_LO = 8'ha8;
   localparam logic [7:0] A_CMP_B_HI = 8'ha9;
   localparam logic [7:0] A_RELOAD_LO = 8'haa;
   localparam logic [7:0] A_RELOAD_HI = 8'hab;
   localparam logic [7:0] A_PWM_CNT_LO = 8'hac;
   localparam logic [7:0] A_PWM_CNT_HI = 8'had;
   localparam logic [7:0] A_PWM_CTRL = 8'hae;
   localparam logic [7:0] A_WAKE_EDGE = 8'haf;
   localparam logic [7:0] A_WAKE_PEND = 8'hb0;
   localparam logic [7:0] A_WAKE_EN = 8'hb1;
   localparam logic [7:0] A_PORT_OUT = 8'hb2;
   localparam logic [7:0] A_PORT_DIR = 8'hb3;
   localparam logic [7:0] A_PORT_PIN = 8'hb4;
   localparam logic [7:0] A_WDOG = 8'hb5;
   localparam logic [7:0] A_TICK_CTRL = 8'hb6;
   localparam logic [7:0] A_POWER_SAVE = 8'hb7;
   localparam logic [7:0] A_INIT_CFG = 8'hbb;
   localparam logic [7:0] A_OSC_TRIM = 8'hbc;
   localparam logic [7:0] A_THRESHOLD = 8'hbd;
   localparam logic [7:0] A_INDEX_HI = 8'hbe;
   localparam logic [7:0] A_INDEX_LO = 8'hbf;
   localparam logic [7:0] A_STACK = 8'hce;
   localparam logic [7:0] A_CORE_FLAGS = 8'hcf;
   localparam logic [7:0] A_ANALOG_TRIM = 8'hd1;
   localparam logic [7:0] A_PIN_TRIM = 8'hd4;
   // ---------------------------------------------
   // storage layout and field masks
   // ---------------------------------------------
   localparam int NUM_SLOTS = 23;
   localparam logic [4:0] NO_SLOT = 5'h1f;
   localparam logic [7:0] SLOT_MASK [NUM_SLOTS] = '{
      8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h0f, 8'hff,
      8'h0f, 8'hff, 8'h0f, 8'hfd, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'h83, 8'h03, 8'hfc, 8'h07, 8'hff, 8'h0f};
   localparam logic [4:0] SLOT_PORT_OUT = 5'd15;
   localparam logic [4:0] SLOT_PORT_DIR = 5'd16;
   localparam int NUM_INIT = 4;
   localparam logic [2:0] NO_INIT = 3'h4;
   localparam logic [1:0] INIT_CFG = 2'd0;
   localparam logic [1:0] INIT_OSC = 2'd1;
   localparam logic [7:0] INIT_MASK [NUM_INIT] = '{
      8'hdf, 8'hff, 8'h3f, 8'hff};
   localparam int WR_DISABLE_BIT = 1;
   localparam int RD_DISABLE_BIT = 0;
   localparam int GINT_BIT = 7;
   localparam logic [6:0] FLAGS_MASK = 7'h1f;
   localparam logic [7:0] WDOG_KEY = 8'h1b;
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int SYS_RESET_NS = 3700000;
   localparam int SYS_RESET_CYCLES =
      (SYS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W = 18;
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_RUN = 3'b010,
      ST_PROG = 3'b100
   } mode_type;
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_ERASE = 2'h2;
endpackage
`default_nettype wire

// File: init_if.sv
`timescale 1ns/10ps
`default_nettype none
interface init_if;
   import regbank_pkg::*;
   logic wr_en;
   logic [1:0] wr_idx;
   logic [7:0] wr_data;
   logic erase;
   logic reload;
   logic [7:0] nv [NUM_INIT];
   logic [7:0] shadow [NUM_INIT];
   modport bank (output wr_en, wr_idx, wr_data, erase, reload,
      input nv, shadow);
   modport store (input wr_en, wr_idx, wr_data, erase, reload,
      output nv, shadow);
endinterface
`default_nettype wire

// File: init_store.sv
`timescale 1ns/10ps
`default_nettype none
module init_store
   import regbank_pkg::*;
#(
   parameter logic [7:0] OSC_FACTORY = 8'h80
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   init_if.store st
);
   // ---------------------------------------------
   // non-volatile copies
   // ---------------------------------------------
   // cells start erased; a system reset must not touch them
   logic [7:0] nv_reg [NUM_INIT] = '{default: 8'h00};

   assign st.nv = nv_reg;

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NUM_INIT; i++) begin
         if (st.wr_en && st.wr_idx == 2'(i)) begin
            nv_reg[i] <= st.wr_data & INIT_MASK[i];
         end
      end
   end
   // ---------------------------------------------
   // working shadows
   // ---------------------------------------------
   // nv writes reach the shadows only at the next system reset, except osc trim, whose shadow always reloads OSC_FACTORY
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NUM_INIT; i++) begin
         if (!rst_n_i) begin
            st.shadow[i] <= (i == INIT_OSC) ? OSC_FACTORY : '0; // R7
         end else if (st.reload) begin
            st.shadow[i] <= (i == INIT_OSC) ? OSC_FACTORY : st.nv[i]; // R6 R7
         end else if (st.erase && i == INIT_CFG) begin
            st.shadow[i] <= '0; // R4
         end
      end
   end

   AST_OSC_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      st.reload |=> st.shadow[INIT_OSC] == OSC_FACTORY) // R7
      else $error("osc trim shadow not restored");
   AST_SHADOW_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      st.reload |=> st.shadow[INIT_CFG] == $past(st.nv[INIT_CFG])) // R6
      else $error("config shadow not loaded");
endmodule // init_store
`default_nettype wire

// File: regbank.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: the core runs only after the system reset sequence has finished.
// R2: programmer access is granted only in programming mode.
// R3: under read or write protection only the full erase is accepted.
// R4: full erase clears code memory and the volatile config shadow.
// R5: after erase access stays open for the rest of the session.
// R6: each nv init register has a volatile shadow that the logic uses; only the config and osc trim shadows feed any logic here.
// R7: every system reset restores the osc trim shadow to factory value.
// R8: read-only registers return live values and ignore writes.
// R9: only the global interrupt mask in the core flags is writable.
// R10: the 12-bit pwm counter is split over two byte registers.
// R11: the counter low byte shows counter bits seven to zero.
// R12: the adc result register shows the latest conversion value.
// R13: ports, peripheral and core registers share the data space.
// R14: unused and reserved bits read zero and ignore writes.
// R15: twelve-bit registers are written per byte with no latch.
module regbank
   import regbank_pkg::*;
#(
   parameter int RESET_CYCLES = SYS_RESET_CYCLES,
   parameter logic [7:0] OSC_FACTORY = 8'h80
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   input wire logic prog_entry_i,
   input wire logic prog_req_i,
   input wire logic [1:0] prog_cmd_i,
   input wire logic [7:0] prog_addr_i,
   input wire logic [7:0] prog_wdata_i,
   output logic prog_ack_o,
   output logic prog_reject_o,
   output logic [7:0] prog_rdata_o,
   input wire logic [7:0] adc_result_i,
   input wire logic [11:0] pwm_counter_i,
   input wire logic [7:0] port_pin_level_i,
   input wire logic comp_out_i,
   input wire logic [6:0] core_flags_i,
   output logic run_o,
   output logic prog_mode_o,
   output logic code_erase_o,
   output logic wdog_service_o,
   output logic global_int_o,
   output logic [7:0] osc_trim_o,
   output logic [7:0] port_data_out_o,
   output logic [7:0] port_direction_o
);
   // ---------------------------------------------
   // address decode
   // ---------------------------------------------
   function automatic logic [4:0] slot_of(input logic [7:0] a);
      unique case (a)
         A_ADC_CTRL_A: slot_of = 5'd0;
         A_ADC_CTRL_B: slot_of = 5'd1;
         A_GATE_DELAY: slot_of = 5'd2;
         A_PWM_PRESCALE: slot_of = 5'd3;
         A_DEAD_TIME: slot_of = 5'd4;
         A_CMP_A_LO: slot_of = 5'd5;
         A_CMP_A_HI: slot_of = 5'd6;
         A_CMP_B_LO: slot_of = 5'd7;
         A_CMP_B_HI: slot_of = 5'd8;
         A_RELOAD_LO: slot_of = 5'd9;
         A_RELOAD_HI: slot_of = 5'd10;
         A_PWM_CTRL: slot_of = 5'd11;
         A_WAKE_EDGE: slot_of = 5'd12;
         A_WAKE_PEND: slot_of = 5'd13;
         A_WAKE_EN: slot_of = 5'd14;
         A_PORT_OUT: slot_of = SLOT_PORT_OUT;
         A_PORT_DIR: slot_of = SLOT_PORT_DIR;
         A_TICK_CTRL: slot_of = 5'd17;
         A_POWER_SAVE: slot_of = 5'd18;
         A_THRESHOLD: slot_of = 5'd19;
         A_INDEX_HI: slot_of = 5'd20;
         A_INDEX_LO: slot_of = 5'd21;
         A_STACK: slot_of = 5'd22;
         default: slot_of = NO_SLOT;
      endcase
   endfunction

   function automatic logic [2:0] init_of(input logic [7:0] a);
      unique case (a)
         A_INIT_CFG: init_of = 3'd0;
         A_OSC_TRIM: init_of = 3'd1;
         A_ANALOG_TRIM: init_of = 3'd2;
         A_PIN_TRIM: init_of = 3'd3;
         default: init_of = NO_INIT;
      endcase
   endfunction

   // ---------------------------------------------
   // system reset sequence and mode
   // ---------------------------------------------
   mode_type mode_reg;
   logic [RST_CNT_W-1:0] rst_cnt_reg;
   logic entry_reg;
   logic seq_done;

   assign seq_done = (rst_cnt_reg == RST_CNT_W'(RESET_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rst_cnt_reg <= '0;
      end else if (mode_reg == ST_RESET) begin
         rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end
   end

   // the entry flag is caught only while the sequence still runs
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         entry_reg <= 1'b0;
      end else if (mode_reg == ST_RESET && prog_entry_i) begin
         entry_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_reg <= ST_RESET;
      end else begin
         unique case (mode_reg)
            ST_RESET: begin
               if (seq_done) begin
                  mode_reg <= (entry_reg || prog_entry_i) ?
                     ST_PROG : ST_RUN; // R1
               end
            end
            ST_RUN: mode_reg <= ST_RUN;
            ST_PROG: mode_reg <= ST_PROG;
            default: mode_reg <= ST_RESET;
         endcase
      end
   end

   // ---------------------------------------------
   // access arbitration
   // ---------------------------------------------
   init_if ini ();
   logic protect;
   logic prog_ok;
   logic erase_go;
   logic prog_bad;
   logic acc_wr;
   logic acc_rd;
   logic [7:0] acc_addr;
   logic [7:0] acc_wdata;
   logic [7:0] rd_value;
   logic [7:0] slot_reg [NUM_SLOTS];
   logic gint_reg;

   assign protect = ini.shadow[INIT_CFG][WR_DISABLE_BIT] |
      ini.shadow[INIT_CFG][RD_DISABLE_BIT]; // R5
   assign prog_ok = prog_req_i && mode_reg == ST_PROG && !protect &&
      (prog_cmd_i == CMD_READ || prog_cmd_i == CMD_WRITE); // R2 R3
   assign erase_go = prog_req_i && mode_reg == ST_PROG &&
      prog_cmd_i == CMD_ERASE; // R3
   assign prog_bad = prog_req_i && !prog_ok && !erase_go; // R2 R3

   always_comb begin
      if (mode_reg == ST_RUN) begin
         acc_addr = bus_addr_i;
         acc_wdata = bus_wdata_i;
         acc_wr = bus_wr_i;
         acc_rd = bus_rd_i;
      end else begin
         acc_addr = prog_addr_i;
         acc_wdata = prog_wdata_i;
         acc_wr = prog_ok && prog_cmd_i == CMD_WRITE;
         acc_rd = prog_ok && prog_cmd_i == CMD_READ;
      end
   end

   // ---------------------------------------------
   // writable storage
   // ---------------------------------------------
   // each byte stands alone; the peripheral owns any pairing
   generate
      for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               slot_reg[g] <= '0;
            end else if (acc_wr && slot_of(acc_addr) == 5'(g)) begin
               slot_reg[g] <= acc_wdata & SLOT_MASK[g]; // R14 R15
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gint_reg <= 1'b0;
      end else if (acc_wr && acc_addr == A_CORE_FLAGS) begin
         gint_reg <= acc_wdata[GINT_BIT]; // R9
      end
   end

   logic [2:0] wr_init;
   assign wr_init = init_of(acc_addr);
   assign ini.wr_en = acc_wr && wr_init != NO_INIT;
   assign ini.wr_idx = wr_init[1:0];
   assign ini.wr_data = acc_wdata;
   assign ini.erase = erase_go; // R4
   assign ini.reload = mode_reg == ST_RESET && seq_done; // R7

   init_store #(
      .OSC_FACTORY(OSC_FACTORY)
   ) u_init_store (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .st(ini.store)
   );

   // ---------------------------------------------
   // read mux
   // ---------------------------------------------
   always_comb begin
      logic [4:0] s;
      logic [2:0] n;
      s = slot_of(acc_addr);
      n = init_of(acc_addr);
      rd_value = '0; // R14
      unique case (acc_addr)
         A_ADC_RESULT: rd_value = adc_result_i; // R12
         A_PWM_CNT_LO: rd_value = pwm_counter_i[7:0]; // R10 R11
         A_PWM_CNT_HI: rd_value = 8'(pwm_counter_i[11:8]); // R10
         A_PORT_PIN: rd_value = port_pin_level_i; // R8
         A_CORE_FLAGS: rd_value = {gint_reg,
            core_flags_i & FLAGS_MASK}; // R9
         A_THRESHOLD: rd_value = slot_reg[s] | 8'(comp_out_i);
         default: begin
            if (s != NO_SLOT) begin
               rd_value = slot_reg[s]; // R13
            end else if (n != NO_INIT) begin
               rd_value = ini.nv[n[1:0]];
            end
         end
      endcase
   end

   // ---------------------------------------------
   // answers
   // ---------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bus_rdata_o <= '0;
      end else if (mode_reg == ST_RUN && acc_rd) begin
         bus_rdata_o <= rd_value;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prog_rdata_o <= '0;
      end else if (mode_reg == ST_PROG && acc_rd) begin
         prog_rdata_o <= rd_value; // R2
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prog_ack_o <= 1'b0;
         prog_reject_o <= 1'b0;
         code_erase_o <= 1'b0;
      end else begin
         prog_ack_o <= prog_req_i;
         prog_reject_o <= prog_bad; // R3
         code_erase_o <= erase_go; // R4
      end
   end

   // a wrong key is simply dropped; the watchdog sees no pulse
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wdog_service_o <= 1'b0;
      end else begin
         wdog_service_o <= acc_wr && acc_addr == A_WDOG &&
            acc_wdata == WDOG_KEY;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         run_o <= 1'b0;
         prog_mode_o <= 1'b0;
         global_int_o <= 1'b0;
         osc_trim_o <= '0;
         port_data_out_o <= '0;
         port_direction_o <= '0;
      end else begin
         run_o <= mode_reg == ST_RUN; // R1
         prog_mode_o <= mode_reg == ST_PROG;
         global_int_o <= gint_reg;
         osc_trim_o <= ini.shadow[INIT_OSC]; // R6
         port_data_out_o <= slot_reg[SLOT_PORT_OUT];
         port_direction_o <= slot_reg[SLOT_PORT_DIR];
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_NO_EARLY_RUN: assert property ( // R1
      mode_reg == ST_RESET && !seq_done |=> !run_o && mode_reg == ST_RESET)
      else $error("core released before reset sequence end");
   AST_NOT_PROG_REJECT: assert property ( // R2
      prog_req_i && mode_reg != ST_PROG |=> prog_reject_o && prog_ack_o)
      else $error("access outside programming mode not refused");
   AST_PROTECT_REJECT: assert property ( // R3
      prog_req_i && mode_reg == ST_PROG && protect &&
      prog_cmd_i != CMD_ERASE |=> prog_reject_o && !code_erase_o)
      else $error("protected access not refused");
   AST_ERASE_CLEARS: assert property ( // R4
      erase_go |=> code_erase_o && ini.shadow[INIT_CFG] == '0)
      else $error("erase did not clear config shadow");
   AST_STAYS_OPEN: assert property ( // R5
      mode_reg == ST_PROG && !protect |=> !protect)
      else $error("protection returned within session");
   AST_PIN_LIVE: assert property ( // R8
      mode_reg == ST_RUN && bus_rd_i && bus_addr_i == A_PORT_PIN
      |=> bus_rdata_o == $past(port_pin_level_i))
      else $error("pin level read wrong");
   AST_FLAGS_MASK: assert property ( // R9
      mode_reg == ST_RUN && bus_wr_i && bus_addr_i == A_CORE_FLAGS
      |-> ##2 global_int_o == $past(bus_wdata_i[GINT_BIT], 2))
      else $error("interrupt mask write lost");
   AST_CNT_HI: assert property ( // R10
      mode_reg == ST_RUN && bus_rd_i && bus_addr_i == A_PWM_CNT_HI
      |=> bus_rdata_o == {4'h0, $past(pwm_counter_i[11:8])})
      else $error("counter high byte wrong");
   AST_CNT_LO: assert property ( // R11
      mode_reg == ST_RUN && bus_rd_i && bus_addr_i == A_PWM_CNT_LO
      |=> bus_rdata_o == $past(pwm_counter_i[7:0]))
      else $error("counter low byte wrong");
   AST_ADC_READ: assert property ( // R12
      mode_reg == ST_RUN && bus_rd_i && bus_addr_i == A_ADC_RESULT
      |=> bus_rdata_o == $past(adc_result_i))
      else $error("adc result read wrong");
   AST_RESERVED_ZERO: assert property ( // R14
      mode_reg == ST_RUN && bus_rd_i && bus_addr_i == A_DEAD_TIME
      |=> bus_rdata_o[7:5] == 3'h0)
      else $error("reserved bits read non-zero");
endmodule // regbank
`default_nettype wire

// File: prog_model.sv
`timescale 1ns/10ps
`default_nettype none
module prog_model (
   input wire logic clk_i,
   output logic entry_o,
   output logic req_o,
   output logic [1:0] cmd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // ---------------------------------------------
   // programmer side of the bank
   // ---------------------------------------------
   initial begin
      entry_o = 1'b0;
      req_o = 1'b0;
      cmd_o = 2'h0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // opcode match raised before the reset sequence ends
   task automatic enter(input logic on);
      @(negedge clk_i);
      entry_o = on;
   endtask
   // held high across back-to-back commands
   task automatic send(input logic [1:0] c, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge clk_i);
      req_o = 1'b1;
      cmd_o = c;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
   endtask
   // released lines carry no stale value
   task automatic idle;
      @(negedge clk_i);
      req_o = 1'b0;
      cmd_o = ~cmd_o;
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
   endtask
endmodule // prog_model
`default_nettype wire

// File: test_memory_mapped_register_file.sv
`timescale 1ns/10ps
`default_nettype none
module test_memory_mapped_register_file;
   import regbank_pkg::*;
   localparam int RST_CYC = 16;
   localparam logic [7:0] FACT = 8'h5a; // arbitrary trim value
   localparam logic [7:0] WA [8] = '{8'ha5, 8'ha6, 8'ha7, 8'hae, 8'hb6,
      8'hb7, 8'hce, 8'hd1};
   localparam logic [7:0] WM [8] = '{8'h1f, 8'hff, 8'h0f, 8'hfd, 8'h83,
      8'h03, 8'h0f, 8'h3f};
   logic clk = 1'b0;
   logic rst_n, wr, rd, run, pmode, erase, wdog, gint, comp;
   logic entry, req, ack, rej;
   logic [1:0] cmd;
   logic [7:0] addr, wdata, rdata, paddr, pwdata, prdata, v;
   logic [7:0] adc, pins, trim, pout, pdir;
   logic [11:0] cnt, pe;
   logic [6:0] flags;
   int num_errors = 0;
   int cmp_count = 0;
   integer seed = 32'h97f8;
   logic [7:0] rq[$];
   logic [11:0] pq[$];
   logic rd_seen = 1'b0;
   logic req_seen = 1'b0;

   regbank #(.RESET_CYCLES(RST_CYC), .OSC_FACTORY(FACT)) DUT (
      .clk_i(clk), .rst_n_i(rst_n), .bus_addr_i(addr), .bus_wr_i(wr),
      .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
      .prog_entry_i(entry), .prog_req_i(req), .prog_cmd_i(cmd),
      .prog_addr_i(paddr), .prog_wdata_i(pwdata), .prog_ack_o(ack),
      .prog_reject_o(rej), .prog_rdata_o(prdata), .adc_result_i(adc),
      .pwm_counter_i(cnt), .port_pin_level_i(pins), .comp_out_i(comp),
      .core_flags_i(flags), .run_o(run), .prog_mode_o(pmode),
      .code_erase_o(erase), .wdog_service_o(wdog), .global_int_o(gint),
      .osc_trim_o(trim), .port_data_out_o(pout),
      .port_direction_o(pdir));

   prog_model prg (.clk_i(clk), .entry_o(entry), .req_o(req),
      .cmd_o(cmd), .addr_o(paddr), .wdata_o(pwdata));

   initial begin
      forever #10 clk = ~clk;
   end
   // ---------------------------------------------
   // checking
   // ---------------------------------------------
   task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      rd_seen <= rd;
      req_seen <= req;
   end
   always @(negedge clk) begin
      if (rd_seen) begin
         check("bus_rdata_o", rdata, rq.pop_front());
      end
      if (req_seen) begin
         pe = pq.pop_front();
         check("prog_flags", {5'h0, ack, rej, erase}, {5'h0, pe[10:8]});
         if (pe[11]) begin
            check("prog_rdata_o", prdata, pe[7:0]);
         end
      end
   end
   // ---------------------------------------------
   // stimulus helpers
   // ---------------------------------------------
   function automatic logic [11:0] pn(input logic c, input logic r,
      input logic e, input logic [7:0] d);
      return {c, 1'b1, r, e, d};
   endfunction
   task automatic core(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge clk);
      wr = w;
      rd = ~w;
      addr = a;
      wdata = d;
      @(posedge clk);
   endtask
   task automatic core_rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      core(1'b0, a, 8'h00);
   endtask
   task automatic quiet;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
   endtask
   task automatic psend(input logic [11:0] e, input logic [1:0] c,
      input logic [7:0] a, input logic [7:0] d);
      pq.push_back(e);
      prg.send(c, a, d);
   endtask
   // bounded: a stuck mode flag ends the run
   task automatic wait_hi(input logic which);
      int n;
      n = 0;
      while ((which ? pmode : run) !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic do_reset(input logic p);
      quiet();
      rst_n = 1'b0;
      prg.enter(p);
      repeat (2) @(negedge clk);
      check("run_o", {7'h0, run}, 8'h00);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check("run_o", {7'h0, run}, 8'h00);
      check("osc_trim_o", trim, FACT);
      wait_hi(p);
      check("prog_mode_o", {7'h0, pmode}, {7'h0, p});
      prg.enter(1'b0);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      adc = 8'h00;
      cnt = 12'h000;
      pins = 8'h00;
      flags = 7'h00;
      comp = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      wait_hi(1'b0);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         core(1'b1, WA[i], v);
         core_rd(WA[i], v & WM[i]);
      end
      quiet();
      adc = 8'($random(seed));
      cnt = 12'($random(seed));
      pins = 8'($random(seed));
      flags = 7'($random(seed));
      comp = 1'($random(seed));
      core(1'b1, A_ADC_RESULT, 8'hff);
      core(1'b1, A_PWM_CNT_LO, 8'hff);
      core(1'b1, A_PWM_CNT_HI, 8'hff);
      core(1'b1, A_PORT_PIN, 8'hff);
      core_rd(A_ADC_RESULT, adc);
      core_rd(A_PWM_CNT_LO, cnt[7:0]);
      core_rd(A_PWM_CNT_HI, {4'h0, cnt[11:8]});
      core_rd(A_PORT_PIN, pins);
      core_rd(8'h9e, 8'h00);
      core(1'b1, A_CORE_FLAGS, 8'hff);
      core_rd(A_CORE_FLAGS, {1'b1, 2'b00, flags[4:0]});
      quiet();
      check("global_int_o", {7'h0, gint}, 8'h01);
      core(1'b1, A_CORE_FLAGS, 8'h00);
      core_rd(A_CORE_FLAGS, {1'b0, 2'b00, flags[4:0]});
      core(1'b1, A_WDOG, WDOG_KEY);
      quiet();
      check("wdog_service_o", {7'h0, wdog}, 8'h01);
      core(1'b1, A_WDOG, 8'h1a);
      quiet();
      check("wdog_service_o", {7'h0, wdog}, 8'h00);
      core(1'b1, A_PORT_OUT, 8'ha5);
      core(1'b1, A_PORT_DIR, 8'h3c);
      core(1'b1, A_OSC_TRIM, 8'h33);
      core(1'b1, A_INIT_CFG, 8'h03);
      core_rd(A_OSC_TRIM, 8'h33);
      core_rd(A_INIT_CFG, 8'h03);
      quiet();
      check("port_data_out_o", pout, 8'ha5);
      check("port_direction_o", pdir, 8'h3c);
      check("osc_trim_o", trim, FACT);
      psend(pn(1'b0, 1'b1, 1'b0, 8'h00), CMD_READ, A_OSC_TRIM, 8'h00);
      prg.idle();
      // protected session: only erase gets through until it runs
      do_reset(1'b1);
      check("run_o", {7'h0, run}, 8'h00);
      psend(pn(1'b0, 1'b1, 1'b0, 8'h00), CMD_READ, A_OSC_TRIM, 8'h00);
      psend(pn(1'b0, 1'b1, 1'b0, 8'h00), CMD_WRITE, A_INDEX_LO, 8'h11);
      psend(pn(1'b0, 1'b0, 1'b1, 8'h00), CMD_ERASE, 8'h00, 8'h00);
      psend(pn(1'b1, 1'b0, 1'b0, 8'h03), CMD_READ, A_INIT_CFG, 8'h00);
      psend(pn(1'b1, 1'b0, 1'b0, 8'h33), CMD_READ, A_OSC_TRIM, 8'h00);
      psend(pn(1'b0, 1'b1, 1'b0, 8'h00), 2'h3, A_INDEX_LO, 8'h00);
      psend(pn(1'b0, 1'b0, 1'b0, 8'h00), CMD_WRITE, A_INDEX_LO, 8'h5c);
      psend(pn(1'b1, 1'b0, 1'b0, 8'h5c), CMD_READ, A_INDEX_LO, 8'h00);
      prg.idle();
      do_reset(1'b0);
      quiet();
      summarize();
   end
endmodule // test_memory_mapped_register_file
`default_nettype wire
